/* File: ddr3_cmd_pkg.sv */
// Package of command encodings, field positions and timing counts for the DDR3 command issuer.
package ddr3_cmd_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int BANKS = 8;
	localparam int BA_W = 3;
	localparam int ADDR_W = 14;
	localparam int DQ_W = 8;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;

	// ------------------------------------------------------------
	// Request opcodes from the user port
	// ------------------------------------------------------------
	localparam logic [3:0] OP_NOP = 4'h0;
	localparam logic [3:0] OP_ACT = 4'h1;
	localparam logic [3:0] OP_PRE = 4'h2;
	localparam logic [3:0] OP_WR = 4'h3;
	localparam logic [3:0] OP_RD = 4'h4;
	localparam logic [3:0] OP_MRS = 4'h5;
	localparam logic [3:0] OP_REF = 4'h6;
	localparam logic [3:0] OP_SRE = 4'h7;
	localparam logic [3:0] OP_PDE = 4'h8;
	localparam logic [3:0] OP_EXIT = 4'h9;
	localparam logic [3:0] OP_ZQ = 4'hA;
	localparam logic [3:0] OP_DES = 4'hB;

	// ------------------------------------------------------------
	// Pin codes for RAS#, CAS#, WE# (CS# low)
	// ------------------------------------------------------------
	localparam logic [2:0] PIN_NOP = 3'h7;
	localparam logic [2:0] PIN_ACT = 3'h3;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_WR = 3'h4;
	localparam logic [2:0] PIN_RD = 3'h5;
	localparam logic [2:0] PIN_MRS = 3'h0;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam logic [2:0] PIN_ZQ = 3'h6;

	// ------------------------------------------------------------
	// Burst framing counts in controller clocks
	// ------------------------------------------------------------
	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam logic [3:0] BEATS_BC4 = 4'h4;

	// ------------------------------------------------------------
	// Request status codes
	// ------------------------------------------------------------
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_ILLEGAL = 2'h1;

endpackage

/* File: ddr3_cmd_host.sv */
// DDR3 command issuer: turns user requests into pin commands and frames write and read bursts.
//
// Contract
// - CS# high is deselect; CS# low with RAS#, CAS#, WE# high is no-op.
// - Activate is RAS# low, CAS# WE# high, CKE high; BA bank, A row.
// - Precharge is RAS# low, CAS# high, WE# low; A10 selects one or all.
// - Write is RAS# high, CAS# WE# low, CKE high, only to active bank.
// - Read is RAS# high, CAS# low, WE# high, CKE high, only to active bank.
// - A10 high on read or write requests auto-precharge after the burst.
// - With on-the-fly enabled, A12 low chops to four, high gives eight.
// - Mode register set is all strobes low, only when all banks idle.
// - Refresh is RAS# CAS# low, WE# high; CKE falling enters self refresh.
// - Self refresh exits on CKE rising with no-op or deselect presented.
// - Power-down enters on CKE falling with no-op or deselect presented.
// - Power-down exits on CKE rising with no-op or deselect presented.
// - Data mask high discards a write beat, low writes it.
// - ZQ calibration is CAS# RAS# high, WE# low when idle; A10 long/short.
// - Controller activates a row before any read or write to that bank.
// - Controller finishes initialisation before activate, read or write.
module ddr3_cmd_host
	import ddr3_cmd_pkg::*;
(
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// User request port.
	input wire logic REQ_VALID_IN,
	input wire logic [3:0] REQ_OP_IN,
	input wire logic [BA_W-1:0] REQ_BANK_IN,
	input wire logic [ADDR_W-1:0] REQ_ADDR_IN,
	input wire logic REQ_AP_IN,
	input wire logic REQ_BC4_IN,
	input wire logic OTF_EN_IN,
	input wire logic INIT_DONE_IN,
	output logic REQ_READY_OUT,
	output logic ACK_OUT,
	output logic [1:0] ACK_STATUS_OUT,
	// User write data, one beat per clock.
	input wire logic [DQ_W-1:0] WDATA_IN,
	input wire logic WMASK_IN,
	output logic WDATA_TAKE_OUT,
	// User read data, one beat per clock.
	output logic [DQ_W-1:0] RDATA_OUT,
	output logic RDATA_VALID_OUT,
	// Memory command pins.
	output logic MEM_CKE_OUT,
	output logic MEM_CSN_OUT,
	output logic MEM_RASN_OUT,
	output logic MEM_CASN_OUT,
	output logic MEM_WEN_OUT,
	output logic [BA_W-1:0] MEM_BA_OUT,
	output logic [ADDR_W-1:0] MEM_ADDR_OUT,
	// Memory data pins.
	input wire logic [DQ_W-1:0] MEM_DQ_IN,
	output logic [DQ_W-1:0] MEM_DQ_OUT,
	output logic MEM_DQ_OE_OUT,
	output logic MEM_DM_OUT
);

	// ------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_RUN = 4'h1,
		S_WBURST = 4'h2,
		S_RBURST = 4'h4,
		S_LOWPWR = 4'h8
	} phase_t;

	phase_t phase_ff;
	logic [BANKS-1:0] open_ff;
	logic [BANKS-1:0] nxt_open;
	logic [3:0] beat_ff;
	logic [BA_W-1:0] burst_bank_ff;
	logic burst_ap_ff;
	logic [DQ_W-1:0] dq_s1_ff;
	logic [DQ_W-1:0] dq_s2_ff;
	logic accept;
	logic legal;
	logic [2:0] pins;

	// Burst length decode: chop only when on-the-fly is enabled and asked for.
	function automatic logic [3:0] burst_len(input logic otf, input logic bc4);
		burst_len = (otf && bc4) ? BEATS_BC4 : BEATS_BL8;
	endfunction

	// Pin code for a request opcode; non-strobe ops present a no-op.
	function automatic logic [2:0] pin_code(input logic [3:0] op);
		unique case (op)
			OP_ACT: pin_code = PIN_ACT;
			OP_PRE: pin_code = PIN_PRE;
			OP_WR: pin_code = PIN_WR;
			OP_RD: pin_code = PIN_RD;
			OP_MRS: pin_code = PIN_MRS;
			OP_REF, OP_SRE: pin_code = PIN_REF;
			OP_ZQ: pin_code = PIN_ZQ;
			default: pin_code = PIN_NOP;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Request legality against bank and power state
	// ------------------------------------------------------------
	// A request is taken in S_RUN or S_LOWPWR; in S_LOWPWR only an exit request is legal.
	assign accept = REQ_VALID_IN && REQ_READY_OUT;
	assign pins = pin_code(REQ_OP_IN);

	// Legality checks the bank chosen by the request and whole-device idleness.
	always_comb begin
		legal = 1'b1;
		unique case (REQ_OP_IN)
			OP_ACT: legal = INIT_DONE_IN && !open_ff[REQ_BANK_IN];
			OP_WR, OP_RD: legal = INIT_DONE_IN && open_ff[REQ_BANK_IN];
			OP_MRS, OP_REF, OP_SRE, OP_ZQ: legal = (open_ff == '0);
			OP_EXIT: legal = (phase_ff == S_LOWPWR);
			OP_PRE, OP_NOP, OP_DES, OP_PDE: legal = (phase_ff == S_RUN);
			default: legal = 1'b0;
		endcase
		if ((phase_ff == S_LOWPWR) && (REQ_OP_IN != OP_EXIT)) begin
			legal = 1'b0;
		end
	end

	// Bank table update for activate, precharge and auto-precharge at burst end.
	always_comb begin
		nxt_open = open_ff;
		if (accept && legal && (REQ_OP_IN == OP_ACT)) begin
			nxt_open[REQ_BANK_IN] = 1'b1;
		end
		if (accept && legal && (REQ_OP_IN == OP_PRE)) begin
			if (REQ_ADDR_IN[AP_BIT]) begin
				nxt_open = '0;
			end else begin
				nxt_open[REQ_BANK_IN] = 1'b0;
			end
		end
		if ((phase_ff == S_WBURST || phase_ff == S_RBURST) && beat_ff == 4'h1 && burst_ap_ff) begin
			nxt_open[burst_bank_ff] = 1'b0;
		end
	end

	// Bank open table register.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			open_ff <= '0;
		end else begin
			open_ff <= nxt_open;
		end
	end

	// ------------------------------------------------------------
	// Phase and burst sequencing
	// ------------------------------------------------------------
	// Phase machine, beat counter and burst bookkeeping.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			phase_ff <= S_RUN;
			beat_ff <= 4'h0;
			burst_bank_ff <= '0;
			burst_ap_ff <= 1'b0;
		end else begin
			unique case (phase_ff)
				S_RUN: begin
					if (accept && legal && (REQ_OP_IN == OP_WR || REQ_OP_IN == OP_RD)) begin
						phase_ff <= (REQ_OP_IN == OP_WR) ? S_WBURST : S_RBURST;
						beat_ff <= burst_len(OTF_EN_IN, REQ_BC4_IN);
						burst_bank_ff <= REQ_BANK_IN;
						burst_ap_ff <= REQ_AP_IN;
					end else if (accept && legal && (REQ_OP_IN == OP_SRE || REQ_OP_IN == OP_PDE)) begin
						phase_ff <= S_LOWPWR;
					end
				end
				S_WBURST, S_RBURST: begin
					beat_ff <= beat_ff - 4'h1;
					if (beat_ff == 4'h1) begin
						phase_ff <= S_RUN;
					end
				end
				S_LOWPWR: begin
					if (accept && legal) begin
						phase_ff <= S_RUN;
					end
				end
				default: phase_ff <= S_RUN;
			endcase
		end
	end

	// Ready only between bursts; low power waits for the exit request.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			REQ_READY_OUT <= 1'b0;
		end else begin
			REQ_READY_OUT <= (phase_ff == S_RUN && !(accept && legal &&
				(REQ_OP_IN == OP_WR || REQ_OP_IN == OP_RD))) ||
				(phase_ff != S_RUN && phase_ff != S_LOWPWR && beat_ff == 4'h1) ||
				(phase_ff == S_LOWPWR);
		end
	end

	// Acknowledge each taken request with its status, one cycle later.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ACK_OUT <= 1'b0;
			ACK_STATUS_OUT <= ST_OK;
		end else begin
			ACK_OUT <= accept;
			ACK_STATUS_OUT <= (accept && !legal) ? ST_ILLEGAL : ST_OK;
		end
	end

	// ------------------------------------------------------------
	// Command pins
	// ------------------------------------------------------------
	// Drive the command for a legal request; otherwise deselect with CS# high.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			MEM_CKE_OUT <= 1'b0;
			MEM_CSN_OUT <= 1'b1;
			{MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} <= PIN_NOP;
			MEM_BA_OUT <= '0;
			MEM_ADDR_OUT <= '0;
		end else begin
			MEM_CSN_OUT <= 1'b1;
			{MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} <= PIN_NOP;
			if (phase_ff == S_RUN && !(accept && legal &&
				(REQ_OP_IN == OP_SRE || REQ_OP_IN == OP_PDE))) begin
				MEM_CKE_OUT <= 1'b1;
			end
			if (accept && legal) begin
				MEM_BA_OUT <= REQ_BANK_IN;
				MEM_ADDR_OUT <= REQ_ADDR_IN;
				if (REQ_OP_IN != OP_DES) begin
					MEM_CSN_OUT <= 1'b0;
				end
				{MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} <= pins;
				if (REQ_OP_IN == OP_WR || REQ_OP_IN == OP_RD) begin
					MEM_ADDR_OUT[AP_BIT] <= REQ_AP_IN;
					MEM_ADDR_OUT[BC_BIT] <= !REQ_BC4_IN;
				end
				if (REQ_OP_IN == OP_SRE || REQ_OP_IN == OP_PDE) begin
					MEM_CKE_OUT <= 1'b0;
				end
				if (REQ_OP_IN == OP_EXIT) begin
					MEM_CKE_OUT <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------
	// Write beats go out with their mask while the write burst runs.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			MEM_DQ_OUT <= '0;
			MEM_DQ_OE_OUT <= 1'b0;
			MEM_DM_OUT <= 1'b0;
			WDATA_TAKE_OUT <= 1'b0;
		end else begin
			MEM_DQ_OE_OUT <= (phase_ff == S_WBURST);
			WDATA_TAKE_OUT <= (phase_ff == S_WBURST);
			MEM_DQ_OUT <= WDATA_IN;
			MEM_DM_OUT <= (phase_ff == S_WBURST) && WMASK_IN;
		end
	end

	// Read data pins pass two flip-flops before use.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
		end else begin
			dq_s1_ff <= MEM_DQ_IN;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	// Read beats are presented while the read burst runs.
	always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			RDATA_OUT <= '0;
			RDATA_VALID_OUT <= 1'b0;
		end else begin
			RDATA_OUT <= dq_s2_ff;
			RDATA_VALID_OUT <= (phase_ff == S_RBURST);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_DESELECT_IGNORES: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_DES) |=> MEM_CSN_OUT)
		else $error("Deselect request did not hold chip select high.");
	AST_ACT_PINS: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_ACT) |=>
		(!MEM_CSN_OUT && !MEM_RASN_OUT && MEM_CASN_OUT && MEM_WEN_OUT && MEM_CKE_OUT))
		else $error("Activate pins wrong.");
	AST_PREALL_CLOSES: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_PRE && REQ_ADDR_IN[AP_BIT]) |=> (open_ff == '0))
		else $error("Precharge all left a bank open.");
	AST_WR_NEEDS_OPEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(!MEM_CSN_OUT && {MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} == PIN_WR) |->
		$past(open_ff[REQ_BANK_IN]))
		else $error("Write issued to a closed bank.");
	AST_RD_PINS: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_RD) |=>
		(!MEM_CSN_OUT && MEM_RASN_OUT && !MEM_CASN_OUT && MEM_WEN_OUT))
		else $error("Read pins wrong.");
	AST_AP_CLOSES: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_RD && REQ_AP_IN && !OTF_EN_IN) |->
		##9 !open_ff[$past(REQ_BANK_IN, 9)])
		else $error("Auto-precharge did not close bank after eight beats.");
	AST_BC4_LEN: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_WR && OTF_EN_IN && REQ_BC4_IN) |=>
		(phase_ff == S_WBURST) [*4] ##1 (phase_ff == S_RUN))
		else $error("Chopped write did not last four beats.");
	AST_MRS_IDLE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(!MEM_CSN_OUT && {MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} == PIN_MRS) |->
		($past(open_ff) == '0))
		else $error("Mode register set while a bank was open.");
	AST_LOWPWR_NOP: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		$fell(MEM_CKE_OUT) |-> (!MEM_CSN_OUT && {MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} ==
		(($past(REQ_OP_IN) == OP_SRE) ? PIN_REF : PIN_NOP)))
		else $error("Power-down entry with a strobe command.");
	AST_EXIT_CKE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && legal && REQ_OP_IN == OP_EXIT) |=>
		(MEM_CKE_OUT && {MEM_RASN_OUT, MEM_CASN_OUT, MEM_WEN_OUT} == PIN_NOP))
		else $error("Exit did not raise clock enable with a no-op.");
	AST_MASK_ONLY_WRITE: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		MEM_DM_OUT |-> MEM_DQ_OE_OUT)
		else $error("Data mask high outside a write burst.");
	AST_ILLEGAL_STILL: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		(accept && !legal && phase_ff == S_RUN) |=> (open_ff == $past(open_ff)))
		else $error("Illegal request changed the bank table.");

endmodule

/* File: ddr3_dev_model.sv */
// Behavioural DDR3 device model that decodes the command pins and tracks bank state.
module ddr3_dev_model
	import ddr3_cmd_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rstn_in,
	// Command pins.
	input wire logic cke_in,
	input wire logic csn_in,
	input wire logic rasn_in,
	input wire logic casn_in,
	input wire logic wen_in,
	input wire logic [BA_W-1:0] ba_in,
	input wire logic [ADDR_W-1:0] addr_in,
	// Data pins.
	input wire logic [DQ_W-1:0] dq_in,
	input wire logic dq_oe_in,
	input wire logic dm_in,
	output logic [DQ_W-1:0] dq_out,
	// Bank state seen by the bench.
	output logic [BANKS-1:0] open_banks_out
);
	logic cke_prev_ff;
	logic low_power_ff;
	logic [BA_W-1:0] last_bank_ff;
	logic [2:0] col_ff;
	logic [DQ_W-1:0] mem_ff [BANKS*8];
	logic [2:0] cmd;

	assign cmd = {rasn_in, casn_in, wen_in};

	// Bank and power state follow the pins sampled on the rising edge.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			open_banks_out <= 8'h00;
			cke_prev_ff <= 1'b0;
			low_power_ff <= 1'b0;
			last_bank_ff <= 3'h0;
			col_ff <= 3'h0;
		end else begin
			cke_prev_ff <= cke_in;
			// Each write beat steps to the next column of the eight-beat word.
			if (dq_oe_in) begin
				col_ff <= col_ff + 3'h1;
			end
			if (cke_prev_ff && !cke_in) begin
				low_power_ff <= 1'b1;
			end else if (!cke_prev_ff && cke_in && (csn_in || cmd == PIN_NOP)) begin
				low_power_ff <= 1'b0;
			end else if (cke_in && !csn_in && !low_power_ff) begin
				case (cmd)
					PIN_ACT: open_banks_out[ba_in] <= 1'b1;
					PIN_PRE: begin
						if (addr_in[AP_BIT]) begin
							open_banks_out <= 8'h00;
						end else begin
							open_banks_out[ba_in] <= 1'b0;
						end
					end
					PIN_WR, PIN_RD: begin
						if (open_banks_out[ba_in]) begin
							last_bank_ff <= ba_in;
							col_ff <= addr_in[2:0];
							open_banks_out[ba_in] <= !addr_in[AP_BIT];
						end
					end
					default: begin
					end // Mode, refresh and calibration leave banks alone.
				endcase
			end
		end
	end

	// Unmasked write beats land in the array; masked beats are dropped.
	always_ff @(posedge clk_in) begin
		if (dq_oe_in && !dm_in) begin
			mem_ff[{last_bank_ff, col_ff}] <= dq_in;
		end
	end

	// The read lines change every cycle so stale data is never mistaken for good data.
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dq_out <= 8'h5A;
		end else begin
			dq_out <= dq_out + 8'h3B;
		end
	end
endmodule

/* File: ddr3_sdram_command_decode_bench.sv */
// Self-checking testbench for the DDR3 command issuer against a device model.
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module ddr3_sdram_command_decode_bench
	import ddr3_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, req_valid, req_ap, req_bc4, otf_en, init_done, wmask, wm_prev;
	logic [3:0] req_op;
	logic [2:0] req_bank, ba;
	logic [13:0] req_addr, addr;
	logic [7:0] wdata, wd_prev, rdata, dq_in, dq_out, open_banks;
	logic req_ready, ack, wdata_take, rdata_valid, cke, csn, rasn, casn, wen, dq_oe, dm;
	logic [1:0] ack_status;
	logic cke_exp;
	logic [23:0] rd_h;
	int fail_count, cmp_count;

	// 25 MHz clock.
	always #20 clk = ~clk;

	ddr3_cmd_host uut (.CLK_IN(clk), .RESETN_IN(resetn), .REQ_VALID_IN(req_valid),
		.REQ_OP_IN(req_op), .REQ_BANK_IN(req_bank), .REQ_ADDR_IN(req_addr),
		.REQ_AP_IN(req_ap), .REQ_BC4_IN(req_bc4), .OTF_EN_IN(otf_en),
		.INIT_DONE_IN(init_done), .REQ_READY_OUT(req_ready), .ACK_OUT(ack),
		.ACK_STATUS_OUT(ack_status), .WDATA_IN(wdata), .WMASK_IN(wmask),
		.WDATA_TAKE_OUT(wdata_take), .RDATA_OUT(rdata), .RDATA_VALID_OUT(rdata_valid),
		.MEM_CKE_OUT(cke), .MEM_CSN_OUT(csn), .MEM_RASN_OUT(rasn), .MEM_CASN_OUT(casn),
		.MEM_WEN_OUT(wen), .MEM_BA_OUT(ba), .MEM_ADDR_OUT(addr), .MEM_DQ_IN(dq_in),
		.MEM_DQ_OUT(dq_out), .MEM_DQ_OE_OUT(dq_oe), .MEM_DM_OUT(dm));

	ddr3_dev_model dev (.clk_in(clk), .rstn_in(resetn), .cke_in(cke), .csn_in(csn),
		.rasn_in(rasn), .casn_in(casn), .wen_in(wen), .ba_in(ba), .addr_in(addr),
		.dq_in(dq_out), .dq_oe_in(dq_oe), .dm_in(dm), .dq_out(dq_in),
		.open_banks_out(open_banks));

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Expected strobe pattern {CS#, RAS#, CAS#, WE#} for a legal request.
	function automatic logic [3:0] exp_pins(input logic [3:0] op);
		case (op)
			OP_ACT: return {1'b0, PIN_ACT};
			OP_PRE: return {1'b0, PIN_PRE};
			OP_WR: return {1'b0, PIN_WR};
			OP_RD: return {1'b0, PIN_RD};
			OP_MRS: return {1'b0, PIN_MRS};
			OP_REF, OP_SRE: return {1'b0, PIN_REF};
			OP_ZQ: return {1'b0, PIN_ZQ};
			default: return {1'b0, PIN_NOP};
		endcase
	endfunction

	// Holds one request until taken, then checks the answer, the pins and any burst.
	task automatic issue(input logic [3:0] op, input logic [2:0] bank,
		input logic [13:0] a, input logic ap, input logic bc4, input logic [1:0] st);
		int n;
		int beats;
		n = 0;
		beats = 0;
		req_op = op;
		req_bank = bank;
		req_addr = a;
		req_ap = ap;
		req_bc4 = bc4;
		req_valid = 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 20);
		if (req_ready !== 1'b1) begin
			fail_count++;
			summarize();
		end
		#2;
		req_valid = 1'b0;
		`CHECK(ack, 1'b1)
		`CHECK(ack_status, st)
		if (st != ST_OK || op == OP_DES) begin
			`CHECK(csn, 1'b1)
		end else begin
			`CHECK({csn, rasn, casn, wen}, exp_pins(op))
		end
		if (st == ST_OK && (op == OP_SRE || op == OP_PDE)) cke_exp = 1'b0;
		if (st == ST_OK && op == OP_EXIT) cke_exp = 1'b1;
		`CHECK(cke, cke_exp)
		if (st == ST_OK && (op == OP_ACT || op == OP_MRS)) begin
			`CHECK({ba, addr}, {bank, a})
		end
		if (st == ST_OK && (op == OP_PRE || op == OP_ZQ)) begin
			`CHECK(addr[AP_BIT], a[AP_BIT])
		end
		if (st == ST_OK && (op == OP_WR || op == OP_RD)) begin
			`CHECK({ba, addr[AP_BIT], addr[9:0]}, {bank, ap, a[9:0]})
			`CHECK(addr[BC_BIT], ~bc4)
			repeat (12) begin
				@(posedge clk);
				#2;
				if ((op == OP_WR) ? wdata_take === 1'b1 : rdata_valid === 1'b1) beats++;
			end
			`CHECK(4'(beats), (otf_en && bc4) ? BEATS_BC4 : BEATS_BL8)
		end
		// Let the model take the command before the caller looks at its state.
		@(posedge clk);
		#2;
	endtask

	// Random write beats, and a record of what the issuer sampled at each edge.
	always @(posedge clk) begin
		wd_prev <= wdata;
		wm_prev <= wmask;
		rd_h <= {rd_h[15:0], dq_in};
		#2;
		wdata = 8'($urandom);
		wmask = 1'($urandom);
	end

	// Each driven write beat carries the sampled data and mask.
	always @(negedge clk) begin
		if (dq_oe === 1'b1) begin
			`CHECK({dq_out, dm}, {wd_prev, wm_prev})
		end
		// Read beats carry the data lines as they stood two clocks earlier.
		if (rdata_valid === 1'b1) begin
			`CHECK(rdata, rd_h[23:16])
		end
	end

	// Main sequence.
	initial begin
		int b;
		clk = 0;
		resetn = 0;
		{req_valid, req_ap, req_bc4, otf_en, init_done, wmask} = 6'h00;
		{req_op, req_bank, req_addr, wdata} = 29'h0;
		{fail_count, cmp_count, cke_exp} = 65'h1;
		void'($urandom(32'hA25F));
		repeat (3) @(posedge clk);
		#2;
		`CHECK({cke, csn}, 2'b01)
		resetn = 1;
		@(posedge clk);
		#2;
		issue(OP_ACT, 3'h1, 14'h0123, 1'b0, 1'b0, ST_ILLEGAL);
		init_done = 1;
		issue(OP_MRS, 3'h2, 14'($urandom), 1'b0, 1'b0, ST_OK);
		issue(OP_ZQ, 3'h0, 14'h0400, 1'b0, 1'b0, ST_OK);
		issue(OP_ZQ, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(OP_REF, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		for (int i = 0; i < 8; i++) begin
			b = $urandom_range(7);
			otf_en = i[1];
			issue(OP_ACT, 3'(b), 14'($urandom), 1'b0, 1'b0, ST_OK);
			`CHECK(open_banks[b], 1'b1)
			issue(OP_ACT, 3'(b), 14'h0000, 1'b0, 1'b0, ST_ILLEGAL);
			issue(OP_MRS, 3'h0, 14'h0000, 1'b0, 1'b0, ST_ILLEGAL);
			issue(OP_WR, 3'(b), 14'($urandom), 1'b0, i[0], ST_OK);
			issue(OP_RD, 3'(b), 14'($urandom), i[2], i[0], ST_OK);
			if (i[2] == 1'b0) issue(OP_PRE, 3'(b), 14'h0000, 1'b0, 1'b0, ST_OK);
			`CHECK(open_banks[b], 1'b0)
			issue(OP_RD, 3'(b), 14'h0000, 1'b0, 1'b0, ST_ILLEGAL);
		end
		issue(OP_ACT, 3'h2, 14'h1FFF, 1'b0, 1'b0, ST_OK);
		issue(OP_ACT, 3'h5, 14'h2000, 1'b0, 1'b0, ST_OK);
		issue(OP_WR, 3'h5, 14'h03FF, 1'b1, 1'b1, ST_OK);
		`CHECK(open_banks, 8'h04)
		issue(OP_PRE, 3'h0, 14'h0400, 1'b0, 1'b0, ST_OK);
		`CHECK(open_banks, 8'h00)
		issue(OP_PDE, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(OP_NOP, 3'h0, 14'h0000, 1'b0, 1'b0, ST_ILLEGAL);
		issue(OP_EXIT, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(OP_SRE, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(OP_REF, 3'h0, 14'h0000, 1'b0, 1'b0, ST_ILLEGAL);
		issue(OP_EXIT, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(OP_DES, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(OP_NOP, 3'h0, 14'h0000, 1'b0, 1'b0, ST_OK);
		issue(4'hC, 3'h0, 14'h0000, 1'b0, 1'b0, ST_ILLEGAL);
		summarize();
	end
endmodule
